//--- pkg/bst_pkg.sv
// boundary-scan test logic: shared widths, codes, reset values and types
// assumes one test-clock domain at the scan port and one system domain
package bst_pkg;

  // ==========================================================
  // widths
  localparam int IR_W       = 8;
  localparam int BND_W      = 48;
  localparam int OPSEL_W    = 3;
  localparam int ID_W       = 32;
  localparam int BND_DATA_W = 36;

  // ==========================================================
  // reset and capture values
  localparam logic [IR_W-1:0]    IR_RESET    = 8'h81;
  localparam logic [IR_W-1:0]    IR_CAPTURE  = 8'h81;
  localparam logic [OPSEL_W-1:0] OPSEL_RESET = 3'h2;
  localparam int                 BND_OE_HI   = 47;
  localparam int                 BND_OE_LO   = 44;
  localparam logic [3:0]         BND_OE_RST  = 4'hF;

  // ==========================================================
  // opcodes, bit 7 is the even-parity bit
  localparam logic [IR_W-1:0] OP_BOUNDARY_TEST = 8'h00;
  localparam logic [IR_W-1:0] OP_IDENT_READ    = 8'h81;
  localparam logic [IR_W-1:0] OP_SAMPLE        = 8'h82;
  localparam logic [IR_W-1:0] OP_HIGHZ         = 8'h06;
  localparam logic [IR_W-1:0] OP_CLAMP         = 8'h87;
  localparam logic [IR_W-1:0] OP_BOUNDARY_RUN  = 8'h09;
  localparam logic [IR_W-1:0] OP_BOUNDARY_READ = 8'h0A;
  localparam logic [IR_W-1:0] OP_OPSEL_SCAN    = 8'h8E;

  // ==========================================================
  // run-test operations
  localparam logic [OPSEL_W-1:0] OPSEL_PATTERN_GEN = 3'h1;
  localparam logic [OPSEL_W-1:0] OPSEL_SIGNATURE   = 3'h2;
  localparam logic [OPSEL_W-1:0] OPSEL_UP_COUNT    = 3'h3;
  localparam logic [BND_DATA_W-1:0] LFSR_TAPS = 36'h8_0000_0800;

  // ==========================================================
  // types
  typedef enum logic [15:0] {
    BST_TLR        = 16'h0001,
    BST_RUN_IDLE   = 16'h0002,
    BST_SEL_DR     = 16'h0004,
    BST_CAPTURE_DR = 16'h0008,
    BST_SHIFT_DR   = 16'h0010,
    BST_EXIT1_DR   = 16'h0020,
    BST_PAUSE_DR   = 16'h0040,
    BST_EXIT2_DR   = 16'h0080,
    BST_UPDATE_DR  = 16'h0100,
    BST_SEL_IR     = 16'h0200,
    BST_CAPTURE_IR = 16'h0400,
    BST_SHIFT_IR   = 16'h0800,
    BST_EXIT1_IR   = 16'h1000,
    BST_PAUSE_IR   = 16'h2000,
    BST_EXIT2_IR   = 16'h4000,
    BST_UPDATE_IR  = 16'h8000
  } bst_tap_state_t;

  typedef enum logic [3:0] {
    BST_DR_BYPASS   = 4'h1,
    BST_DR_IDENT    = 4'h2,
    BST_DR_BOUNDARY = 4'h4,
    BST_DR_OPSEL    = 4'h8
  } bst_dr_sel_t;

endpackage

//--- rtl/bst_sync.sv
// two-flop level synchroniser, width set by parameter
// assumes the source is quiet long enough to be sampled as a whole
`timescale 1ns/10ps

module bst_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  // data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] hold;
  } bst_sync_t;

  bst_sync_t s_reg;
  bst_sync_t s_next;

  // first stage feeds only the second
  always_comb begin
    s_next      = s_reg;
    s_next.meta = i_d;
    s_next.hold = s_reg.meta;
    if (!i_rstn) begin
      s_next = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    s_reg <= s_next;
  end

  assign o_q = s_reg.hold;

endmodule

//--- rtl/bst_scan_top.sv
// boundary-scan test logic: tap controller, instruction, boundary,
// op-select, bypass and ident registers, shadows handed to the system
// assumes tck comes from an external test controller; captures are async
`timescale 1ns/10ps

module bst_scan_top #(
  parameter logic [31:0] ID_VALUE = 32'h0000_0001  // arbitrary value, lsb one
) (
  // system clock and reset
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rstn,
  // test access port
  input  wire logic                          i_tck,
  input  wire logic                          i_tms,
  input  wire logic                          i_tdi,
  output logic                               o_tdo,
  output logic                               o_tdo_oe_n,
  // boundary capture levels, asynchronous
  input  wire logic [bst_pkg::BND_W-1:0]     i_bnd_capture,
  // test shadows on the system side
  output logic                               o_test_mode,
  output logic                               o_highz_mode,
  output logic [bst_pkg::OPSEL_W-1:0]        o_opsel,
  output logic [bst_pkg::BND_W-1:0]          o_bnd_drive
);

  import bst_pkg::*;

  // ==========================================================
  // state types
  typedef struct packed {
    bst_tap_state_t       state;
    logic [IR_W-1:0]      ir_shift;
    logic [BND_W-1:0]     bnd_shift;
    logic [OPSEL_W-1:0]   op_shift;
    logic [ID_W-1:0]      id_shift;
    logic                 byp_shift;
  } bst_rise_t;

  typedef struct packed {
    logic [IR_W-1:0]      ir_shadow;
    logic [BND_W-1:0]     bnd_shadow;
    logic [OPSEL_W-1:0]   op_shadow;
    logic                 tdo;
    logic                 tdo_oe_n;
    logic                 upd_tgl;
  } bst_fall_t;

  typedef struct packed {
    logic                 tgl_seen;
    logic                 test_mode;
    logic                 highz_mode;
    logic [OPSEL_W-1:0]   opsel;
    logic [BND_W-1:0]     bnd_drive;
  } bst_sys_t;

  bst_rise_t            tp_reg;
  bst_rise_t            tp_next;
  bst_fall_t            tn_reg;
  bst_fall_t            tn_next;
  bst_sys_t             sys_reg;
  bst_sys_t             sys_next;
  logic                 tck_rstn;
  logic                 tgl_sync;
  logic [BND_W-1:0]     cap_sync;
  bst_dr_sel_t          dr_sel;
  logic                 test_mode;
  logic                 highz_mode;
  logic                 run_op;
  logic                 lfsr_fb;
  logic                 ir_lsb;
  logic [IR_W-2:0]      ir_upper;
  logic                 shadow_chg;

  // ==========================================================
  // crossings
  // test-side reset follows the system reset; tck must run while it is low
  bst_sync #(.W(1)) u_rst_sync (
    .i_clk  (i_tck),
    .i_rstn (1'b1),
    .i_d    (i_rstn),
    .o_q    (tck_rstn)
  );

  bst_sync #(.W(BND_W)) u_cap_sync (
    .i_clk  (i_tck),
    .i_rstn (tck_rstn),
    .i_d    (i_bnd_capture),
    .o_q    (cap_sync)
  );

  bst_sync #(.W(1)) u_tgl_sync (
    .i_clk  (i_clk_sys),
    .i_rstn (i_rstn),
    .i_d    (tn_reg.upd_tgl),
    .o_q    (tgl_sync)
  );

  // ==========================================================
  // instruction decode
  // opcode decode
  function automatic bst_dr_sel_t bst_decode(input logic [IR_W-1:0] op);
    bst_dr_sel_t sel;
    sel = BST_DR_BYPASS;
    if (!(^op)) begin
      case (op)
        OP_BOUNDARY_TEST: sel = BST_DR_BOUNDARY;
        OP_SAMPLE:        sel = BST_DR_BOUNDARY;
        OP_BOUNDARY_READ: sel = BST_DR_BOUNDARY;
        OP_IDENT_READ:    sel = BST_DR_IDENT;
        OP_OPSEL_SCAN:    sel = BST_DR_OPSEL;
        default:          sel = BST_DR_BYPASS;
      endcase
    end
    return sel;
  endfunction

  assign dr_sel     = bst_decode(tn_reg.ir_shadow);
  assign highz_mode = (tn_reg.ir_shadow == OP_HIGHZ);
  assign run_op     = (tn_reg.ir_shadow == OP_BOUNDARY_RUN);
  assign test_mode  = (tn_reg.ir_shadow == OP_BOUNDARY_TEST) || (tn_reg.ir_shadow == OP_CLAMP)
                      || run_op || highz_mode;
  assign lfsr_fb    = ^(tp_reg.bnd_shift[BND_DATA_W-1:0] & LFSR_TAPS);
  assign ir_lsb     = tp_reg.ir_shift[0];
  assign ir_upper   = tp_reg.ir_shift[IR_W-1:1];

  // ==========================================================
  // tap controller
  function automatic bst_tap_state_t bst_tap_step(input bst_tap_state_t s, input logic tms);
    bst_tap_state_t nx;
    nx = BST_TLR;
    unique case (s)
      BST_TLR:        nx = tms ? BST_TLR       : BST_RUN_IDLE;
      BST_RUN_IDLE:   nx = tms ? BST_SEL_DR    : BST_RUN_IDLE;
      BST_SEL_DR:     nx = tms ? BST_SEL_IR    : BST_CAPTURE_DR;
      BST_CAPTURE_DR: nx = tms ? BST_EXIT1_DR  : BST_SHIFT_DR;
      BST_SHIFT_DR:   nx = tms ? BST_EXIT1_DR  : BST_SHIFT_DR;
      BST_EXIT1_DR:   nx = tms ? BST_UPDATE_DR : BST_PAUSE_DR;
      BST_PAUSE_DR:   nx = tms ? BST_EXIT2_DR  : BST_PAUSE_DR;
      BST_EXIT2_DR:   nx = tms ? BST_UPDATE_DR : BST_SHIFT_DR;
      BST_UPDATE_DR:  nx = tms ? BST_SEL_DR    : BST_RUN_IDLE;
      BST_SEL_IR:     nx = tms ? BST_TLR       : BST_CAPTURE_IR;
      BST_CAPTURE_IR: nx = tms ? BST_EXIT1_IR  : BST_SHIFT_IR;
      BST_SHIFT_IR:   nx = tms ? BST_EXIT1_IR  : BST_SHIFT_IR;
      BST_EXIT1_IR:   nx = tms ? BST_UPDATE_IR : BST_PAUSE_IR;
      BST_PAUSE_IR:   nx = tms ? BST_EXIT2_IR  : BST_PAUSE_IR;
      BST_EXIT2_IR:   nx = tms ? BST_UPDATE_IR : BST_SHIFT_IR;
      BST_UPDATE_IR:  nx = tms ? BST_SEL_DR    : BST_RUN_IDLE;
    endcase
    return nx;
  endfunction

  // ==========================================================
  // rising-edge logic: state and shift stages
  always_comb begin
    tp_next = tp_reg;
    tp_next.state = bst_tap_step(tp_reg.state, i_tms);
    // exits and pauses leave shifters alone
    case (tp_reg.state)
      BST_CAPTURE_IR: tp_next.ir_shift = IR_CAPTURE;
      BST_SHIFT_IR:   tp_next.ir_shift = {i_tdi, ir_upper};
      BST_CAPTURE_DR: begin
        unique case (dr_sel)
          BST_DR_BYPASS:   tp_next.byp_shift = 1'b0;
          BST_DR_IDENT:    tp_next.id_shift = ID_VALUE;
          BST_DR_BOUNDARY: tp_next.bnd_shift = (tn_reg.ir_shadow == OP_BOUNDARY_READ)
                                               ? tn_reg.bnd_shadow : cap_sync;
          BST_DR_OPSEL:    tp_next.op_shift = tp_reg.op_shift;
        endcase
      end
      BST_SHIFT_DR: begin
        unique case (dr_sel)
          BST_DR_BYPASS:   tp_next.byp_shift = i_tdi;
          BST_DR_IDENT:    tp_next.id_shift = {i_tdi, tp_reg.id_shift[ID_W-1:1]};
          // in at cell 47, out at cell 0
          BST_DR_BOUNDARY: tp_next.bnd_shift = {i_tdi, tp_reg.bnd_shift[BND_W-1:1]};
          BST_DR_OPSEL:    tp_next.op_shift = {i_tdi, tp_reg.op_shift[OPSEL_W-1:1]};
        endcase
      end
      BST_RUN_IDLE: begin
        if (run_op) begin
          if (tn_reg.op_shadow == OPSEL_PATTERN_GEN) begin
            tp_next.bnd_shift[BND_DATA_W-1:0] = {tp_reg.bnd_shift[BND_DATA_W-2:0], lfsr_fb};
          end else if (tn_reg.op_shadow == OPSEL_SIGNATURE) begin
            tp_next.bnd_shift[BND_DATA_W-1:0] = {tp_reg.bnd_shift[BND_DATA_W-2:0], lfsr_fb}
                                                ^ cap_sync[BND_DATA_W-1:0];
          end else if (tn_reg.op_shadow == OPSEL_UP_COUNT) begin
            tp_next.bnd_shift[BND_DATA_W-1:0] = tp_reg.bnd_shift[BND_DATA_W-1:0] + 1'b1;
          end
        end
      end
      // enable cells benign in test reset
      BST_TLR: tp_next.bnd_shift[BND_OE_HI:BND_OE_LO] = BND_OE_RST;
      default: ;
    endcase
    if (!tck_rstn) begin
      tp_next          = '0;
      tp_next.state    = BST_TLR;
      tp_next.ir_shift = IR_RESET;
      tp_next.op_shift = OPSEL_RESET;
      tp_next.bnd_shift[BND_OE_HI:BND_OE_LO] = BND_OE_RST;
    end
  end

  always_ff @(posedge i_tck) begin
    tp_reg <= tp_next;
  end

  // ==========================================================
  // falling-edge logic: serial out and shadows
  always_comb begin
    tn_next = tn_reg;
    tn_next.tdo_oe_n = 1'b1;
    if (tp_reg.state == BST_SHIFT_IR) begin
      tn_next.tdo      = ir_lsb;
      tn_next.tdo_oe_n = 1'b0;
    end else if (tp_reg.state == BST_SHIFT_DR) begin
      tn_next.tdo_oe_n = 1'b0;
      unique case (dr_sel)
        BST_DR_BYPASS:   tn_next.tdo = tp_reg.byp_shift;
        BST_DR_IDENT:    tn_next.tdo = tp_reg.id_shift[0];
        BST_DR_BOUNDARY: tn_next.tdo = tp_reg.bnd_shift[0];
        BST_DR_OPSEL:    tn_next.tdo = tp_reg.op_shift[0];
      endcase
    end
    if (tp_reg.state == BST_UPDATE_IR) begin
      tn_next.ir_shadow = tp_reg.ir_shift;
    end
    if (tp_reg.state == BST_UPDATE_DR) begin
      if (dr_sel == BST_DR_BOUNDARY) begin
        tn_next.bnd_shadow = tp_reg.bnd_shift;
      end else if (dr_sel == BST_DR_OPSEL) begin
        tn_next.op_shadow = tp_reg.op_shift;
      end
    end
    // run patterns reach the driven cells
    if ((tp_reg.state == BST_RUN_IDLE) && run_op) begin
      tn_next.bnd_shadow[BND_DATA_W-1:0] = tp_reg.bnd_shift[BND_DATA_W-1:0];
    end
    if (tp_reg.state == BST_TLR) begin
      tn_next.ir_shadow = IR_RESET;
      tn_next.op_shadow = OPSEL_RESET;
      tn_next.bnd_shadow[BND_OE_HI:BND_OE_LO] = BND_OE_RST;
    end
    // any shadow change is announced to the system side by a toggle
    shadow_chg = (tn_next.ir_shadow != tn_reg.ir_shadow) || (tn_next.op_shadow != tn_reg.op_shadow)
                 || (tn_next.bnd_shadow != tn_reg.bnd_shadow);
    if (shadow_chg) begin
      tn_next.upd_tgl = ~tn_reg.upd_tgl;
    end
    if (!tck_rstn) begin
      tn_next           = '0;
      tn_next.ir_shadow = IR_RESET;
      tn_next.op_shadow = OPSEL_RESET;
      tn_next.tdo_oe_n  = 1'b1;
      tn_next.bnd_shadow[BND_OE_HI:BND_OE_LO] = BND_OE_RST;
    end
  end

  always_ff @(negedge i_tck) begin
    tn_reg <= tn_next;
  end

  assign o_tdo      = tn_reg.tdo;
  assign o_tdo_oe_n = tn_reg.tdo_oe_n;

  // ==========================================================
  // system side
  // the shadow word is sampled after the toggle has settled; it must not
  // change again within three system cycles, which scan timing guarantees
  always_comb begin
    sys_next          = sys_reg;
    sys_next.tgl_seen = tgl_sync;
    if (tgl_sync != sys_reg.tgl_seen) begin
      sys_next.test_mode  = test_mode;
      sys_next.highz_mode = highz_mode;
      sys_next.opsel      = tn_reg.op_shadow;
      sys_next.bnd_drive  = tn_reg.bnd_shadow;
    end
    if (!i_rstn) begin
      sys_next       = '0;
      sys_next.opsel = OPSEL_RESET;
      sys_next.bnd_drive[BND_OE_HI:BND_OE_LO] = BND_OE_RST;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    sys_reg <= sys_next;
  end

  assign o_test_mode  = sys_reg.test_mode;
  assign o_highz_mode = sys_reg.highz_mode;
  assign o_opsel      = sys_reg.opsel;
  assign o_bnd_drive  = sys_reg.bnd_drive;

  // ==========================================================
  // assertions
  a_reset_walk: assert property (@(posedge i_tck) disable iff (!tck_rstn)
    i_tms [*5] |=> tp_reg.state == BST_TLR)
    else $error("five high mode selects did not reach test reset");

  a_ir_capture: assert property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_CAPTURE_IR |=> tp_reg.ir_shift == IR_CAPTURE)
    else $error("instruction capture value wrong");

  a_ir_shift_step: assert property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_SHIFT_IR |=>
      tp_reg.ir_shift[IR_W-2:0] == $past(ir_upper) && tp_reg.ir_shift[IR_W-1] == $past(i_tdi))
    else $error("instruction shift did not move one bit");

  a_ir_pause_hold: assert property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_PAUSE_IR |=> $stable(tp_reg.ir_shift))
    else $error("instruction bits lost in pause");

  a_dr_pause_hold: assert property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_PAUSE_DR |=> $stable(tp_reg.bnd_shift) && $stable(tp_reg.id_shift)
      && $stable(tp_reg.op_shift))
    else $error("data bits lost in pause");

  a_dr_resume: assert property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_EXIT2_DR && !i_tms |=> tp_reg.state == BST_SHIFT_DR && $stable(tp_reg.bnd_shift))
    else $error("resume from exit recaptured data");

  a_out_float: assert property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_EXIT1_DR || tp_reg.state == BST_EXIT1_IR |-> tn_reg.tdo_oe_n)
    else $error("serial out still driven in exit");

  a_ir_out_lsb: assert property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_SHIFT_IR |-> !tn_reg.tdo_oe_n && tn_reg.tdo == ir_lsb)
    else $error("serial out not instruction lsb");

  a_ir_update: assert property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_UPDATE_IR |-> tn_reg.ir_shadow == tp_reg.ir_shift)
    else $error("instruction shadow not loaded on update");

  a_ir_reset: assert property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_TLR |=> tn_reg.ir_shadow == IR_RESET && tn_reg.op_shadow == OPSEL_RESET)
    else $error("test reset values wrong");

  a_opsel_keep: assert property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_CAPTURE_DR |=> $stable(tp_reg.op_shift))
    else $error("op-select changed on capture");

  a_bypass_zero: assert property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_CAPTURE_DR && dr_sel == BST_DR_BYPASS |=> !tp_reg.byp_shift)
    else $error("bypass did not capture zero");

  a_parity_bypass: assert property (@(posedge i_tck) disable iff (!tck_rstn)
    (^tn_reg.ir_shadow) |-> dr_sel == BST_DR_BYPASS)
    else $error("odd-parity opcode not decoded as bypass");

  c_ir_update: cover property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_UPDATE_IR);

  c_dr_resume: cover property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_PAUSE_DR ##1 tp_reg.state == BST_EXIT2_DR ##1 tp_reg.state == BST_SHIFT_DR);

  c_run_op: cover property (@(posedge i_tck) disable iff (!tck_rstn)
    tp_reg.state == BST_RUN_IDLE && run_op);

endmodule

//--- test/bst_tap_master.sv
// test controller model: gated test clock, mode select and serial data
// assumes the port samples on rising tck and drives tdo on falling tck
`timescale 1ns/10ps
module bst_tap_master (
  // test bus
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe_n
);
  logic tdo_w;
  // no pull on the line, so a released tdo reads as floating
  assign tdo_w = i_tdo_oe_n ? 1'bz : i_tdo;
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // ==========================================================
  // one state per rising edge; tck stands still between steps
  task automatic step(input logic tms, input logic tdi, output logic seen);
    o_tms = tms;
    o_tdi = tdi;
    #3 o_tck = 1'b1;
    seen = tdo_w;
    #3 o_tck = 1'b0;
  endtask
  // pause after bit brk, then resume shift without recapture
  task automatic scan(input logic ir, input int n, input int brk, input logic [47:0] din,
                      output logic [47:0] dout, output logic pz);
    logic s;
    dout = '0;
    pz = 1'b0;
    step(1'b1, 1'b0, s);
    if (ir) step(1'b1, 1'b0, s);
    repeat (2) step(1'b0, 1'b0, s);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == brk, din[i], dout[i]);
      if (i == brk && i < n - 1) begin
        repeat (3) step(1'b0, 1'b0, pz);
        step(1'b1, 1'b0, s);
        step(1'b0, 1'b0, s);
      end
    end
    step(1'b1, 1'b0, s);
    if (brk < 0 || brk >= n - 1) pz = s;
    step(1'b0, 1'b0, s);
  endtask
endmodule

//--- test/boundary_scan_tap_registers_bench.sv
// bench: drives the scan port through the controller model and checks results
// assumes shadows reach the system outputs within six system cycles
`timescale 1ns/10ps
module boundary_scan_tap_registers_bench;
  import bst_pkg::*;
  // ==========================================================
  // signals
  localparam logic [31:0] ID = 32'h5A3C_0F01;  // arbitrary value, lsb one
  logic               i_clk_sys;
  logic               i_rstn;
  logic               tck, tms, tdi, tdo, tdo_oe_n, test_mode, highz_mode, pz, s;
  logic [OPSEL_W-1:0] opsel;
  logic [BND_W-1:0]   bnd_cap, bnd_drive, got, pat;
  logic [7:0]         op;
  int                 n_errors, n_checks;
  logic [7:0]         byp_ops[6] = '{8'h03, 8'h84, 8'h05, 8'h88, 8'h02, 8'h80};
  logic [7:0]         mode_ops[6] = '{OP_BOUNDARY_TEST, OP_HIGHZ, OP_CLAMP, OP_BOUNDARY_RUN, OP_SAMPLE, OP_IDENT_READ};
  logic [1:0]         mode_exp[6] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h0, 2'h0};  // test, highz

  bst_scan_top #(.ID_VALUE(ID)) i_bst_scan_top (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n), .i_bnd_capture(bnd_cap), .o_test_mode(test_mode),
    .o_highz_mode(highz_mode), .o_opsel(opsel), .o_bnd_drive(bnd_drive));
  bst_tap_master i_bst_tap_master (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n));

  // ==========================================================
  // tasks
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // shadows cross in 3..4 system edges, so six is a safe margin
  task automatic settle();
    repeat (6) @(negedge i_clk_sys);
  endtask
  task automatic load_ir(input logic [7:0] code, input int brk);
    i_bst_tap_master.scan(1'b1, 8, brk, {40'h0, code}, got, pz);
    check(got, {40'h0, IR_CAPTURE});
    check({47'h0, pz}, {47'h0, 1'bz});
    settle();
  endtask
  task automatic run_dr(input int n, input int brk, input logic [47:0] din, input logic [47:0] exp);
    i_bst_tap_master.scan(1'b0, n, brk, din, got, pz);
    check(got, exp);
    check({47'h0, pz}, {47'h0, 1'bz});
    settle();
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // clock and watchdog
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // the tests need about 10 us; give up at twenty times that
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end

  // ==========================================================
  // tests
  initial begin
    n_errors = 0;
    n_checks = 0;
    i_rstn = 1'b0;
    bnd_cap = '0;
    pat = {16'($urandom(32'hE08F536F)), $urandom()};
    repeat (2) @(negedge i_clk_sys);
    repeat (6) i_bst_tap_master.step(1'b1, 1'b0, s);
    repeat (5) @(negedge i_clk_sys);
    check(bnd_drive, {BND_OE_RST, 44'h0});
    check({42'h0, tdo_oe_n, test_mode, highz_mode, opsel}, {42'h0, 3'h4, OPSEL_RESET});
    i_rstn = 1'b1;
    repeat (3) i_bst_tap_master.step(1'b1, 1'b0, s);
    i_bst_tap_master.step(1'b0, 1'b0, s);
    run_dr(32, 13, pat, {16'h0, ID});
    $display("test ident done");
    for (int i = 0; i < 8; i++) begin
      op = (i < 6) ? byp_ops[i] : 8'($urandom());
      if (i >= 6) op[7] = ~^op[6:0];
      load_ir(op, i);
      pat = {16'($urandom()), $urandom()};
      run_dr(2, -1, pat, {46'h0, pat[0], 1'b0});
      check({47'h0, test_mode}, 48'h0);
    end
    $display("test bypass done");
    for (int i = 0; i < 6; i++) begin
      load_ir(mode_ops[i], -1);
      check({46'h0, test_mode, highz_mode}, {46'h0, mode_exp[i]});
    end
    $display("test modes done");
    load_ir(OP_SAMPLE, 3);
    bnd_cap = {16'($urandom()), $urandom()};
    pat = {16'($urandom()), $urandom()};
    repeat (2) i_bst_tap_master.step(1'b0, 1'b0, s);
    run_dr(48, 20, pat, bnd_cap);
    check(bnd_drive, pat);
    load_ir(OP_BOUNDARY_READ, -1);
    run_dr(48, -1, ~pat, pat);
    check(bnd_drive, ~pat);
    $display("test boundary done");
    load_ir(OP_OPSEL_SCAN, -1);
    run_dr(3, -1, {45'h0, OPSEL_UP_COUNT}, {45'h0, OPSEL_RESET});
    check({45'h0, opsel}, {45'h0, OPSEL_UP_COUNT});
    run_dr(3, 1, {45'h0, OPSEL_PATTERN_GEN}, {45'h0, OPSEL_UP_COUNT});
    check({45'h0, opsel}, {45'h0, OPSEL_PATTERN_GEN});
    $display("test opsel done");
    // tck pauses between run steps so every new count reaches the system side
    run_dr(3, -1, {45'h0, OPSEL_UP_COUNT}, {45'h0, OPSEL_PATTERN_GEN});
    load_ir(OP_BOUNDARY_RUN, -1);
    for (int k = 1; k <= 3; k++) begin
      i_bst_tap_master.step(1'b0, 1'b0, s);
      settle();
      check({12'h0, bnd_drive[BND_DATA_W-1:0]}, {12'h0, 36'(~pat[BND_DATA_W-1:0] + k)});
    end
    $display("test run done");
    load_ir(OP_CLAMP, -1);
    repeat (5) i_bst_tap_master.step(1'b1, 1'b0, s);
    settle();
    check({45'h0, opsel}, {45'h0, OPSEL_RESET});
    check({44'h0, bnd_drive[BND_OE_HI:BND_OE_LO]}, {44'h0, BND_OE_RST});
    check({47'h0, test_mode}, 48'h0);
    i_bst_tap_master.step(1'b0, 1'b0, s);
    run_dr(32, -1, pat, {16'h0, ID});
    $display("test reset done");
    finish_test();
  end
endmodule
